// ===== rtl/legacy_timer_mode_clock_select.sv
// How it works
// - clock-control bits 7..5 always read zero, writes to them ignored
// - timer 1 counting pin edges ignores its clock-select bit
// - timer 1 timer function: select 0 prescaled clock, 1 system clock
// - timer 0 counting pin edges ignores its clock-select bit
// - timer 0 timer function: select 0 prescaled clock, 1 system clock
// - timer counts when run is set and gate clear or interrupt pin high; timer 1 holds in mode 3 and ignores run and gate while timer 0 is split
// - counter function advances once per pin high-to-low transition, except on timer 1 while timer 0 is split
// - prescaler: system clock /12, /4, /48, or external clock /8
// - split mode upper byte runs on timer 1 run, sets timer 1 flag
`timescale 1ns/100ps
module legacy_timer_mode_clock_select
   import tmr_pkg::*;
(
   input wire logic mclk, // system clock
   input wire logic rstn, // async reset, low
   input wire logic [tmr_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [tmr_pkg::DATA_W-1:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // byte enables
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [tmr_pkg::ADDR_W-1:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [tmr_pkg::DATA_W-1:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read valid
   input wire logic s_axi_rready, // read ready
   input wire logic firstTimerCountPin, // timer 0 count input
   input wire logic secondTimerCountPin, // timer 1 count input
   input wire logic firstExtInterruptInputN, // timer 0 gate input
   input wire logic secondExtInterruptInputN, // timer 1 gate input
   input wire logic extClk, // external clock
   output logic firstTimerOverflowFlag, // timer 0 overflow, sticky
   output logic secondTimerOverflowFlag // timer 1 overflow, sticky
);
   // bus state
   logic awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
   logic [7:0] awAddr_reg, awAddr_next;
   logic [31:0] wData_reg, wData_next;
   logic [3:0] wStrb_reg, wStrb_next;
   logic bValid_reg, bValid_next, rValid_reg, rValid_next;
   logic [1:0] bResp_reg, bResp_next, rResp_reg, rResp_next;
   logic [31:0] rData_reg, rData_next;
   logic doWrite, okAddr;
   // block state
   logic [7:0] mode_reg, mode_next, clk_reg, clk_next;
   logic run0_reg, run0_next, run1_reg, run1_next;
   logic ovf0_reg, ovf0_next, ovf1_reg, ovf1_next;
   logic [7:0] tl0_reg, tl0_next, th0_reg, th0_next;
   logic [7:0] tl1_reg, tl1_next, th1_reg, th1_next;
   timer_cfg_t cfg0, cfg1;
   logic split, en0, en1, hiEn, hiTick, tick0, tick1, preTick;
   logic set0, set1, wrCnt0, wrCnt1;
   logic [16:0] st0, st1;
   // one count step for a timer pair in the given mode
   function automatic logic [16:0] step(tmode_t m, logic [7:0] hi,
      logic [7:0] lo);
      logic [13:0] s13;
      logic [16:0] s16;
      logic [8:0] s8;
      s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      s16 = {1'b0, hi, lo} + 17'h00001;
      s8 = {1'b0, lo} + 9'h001;
      case (m)
         MODE_13BIT: step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
         MODE_16BIT: step = s16;
         MODE_RELOAD8: step = s8[8] ? {1'b1, hi, hi} : {1'b0, hi, s8[7:0]};
         default: step = {s8[8], hi, s8[7:0]};
      endcase
   endfunction
   // shared prescaler
   tmr_prescaler u_presc (
      .mclk(mclk),
      .rstn(rstn),
      .sel(presc_t'(clk_reg[CLK_SCA_LSB +: 2])),
      .extClk(extClk),
      .tick(preTick)
   );
   // timer 0 count source
   tmr_count_source u_src0 (
      .mclk(mclk),
      .rstn(rstn),
      .clkSel(clk_reg[CLK_T0SEL_BIT]),
      .counterSel(cfg0.counterSel),
      .extAllowed(1'b1),
      .prescaleTick(preTick),
      .countPin(firstTimerCountPin),
      .tick(tick0)
   );
   // timer 1 count source, no pin clocking while timer 0 split
   tmr_count_source u_src1 (
      .mclk(mclk),
      .rstn(rstn),
      .clkSel(clk_reg[CLK_T1SEL_BIT]),
      .counterSel(cfg1.counterSel),
      .extAllowed(!split),
      .prescaleTick(preTick),
      .countPin(secondTimerCountPin),
      .tick(tick1)
   );
   // bus handshakes and outputs
   assign s_axi_awready = !awHeld_reg && !bValid_reg;
   assign s_axi_wready = !wHeld_reg && !bValid_reg;
   assign s_axi_arready = !rValid_reg;
   assign s_axi_bvalid = bValid_reg;
   assign s_axi_bresp = bResp_reg;
   assign s_axi_rvalid = rValid_reg;
   assign s_axi_rresp = rResp_reg;
   assign s_axi_rdata = rData_reg;
   assign firstTimerOverflowFlag = ovf0_reg;
   assign secondTimerOverflowFlag = ovf1_reg;
   assign doWrite = awHeld_reg && wHeld_reg;
   // bus next state and read mux
   always_comb
   begin
      awHeld_next = awHeld_reg;
      wHeld_next = wHeld_reg;
      awAddr_next = awAddr_reg;
      wData_next = wData_reg;
      wStrb_next = wStrb_reg;
      bValid_next = bValid_reg;
      bResp_next = bResp_reg;
      rValid_next = rValid_reg;
      rResp_next = rResp_reg;
      rData_next = rData_reg;
      okAddr = 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
         awHeld_next = 1'b1;
         awAddr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         wHeld_next = 1'b1;
         wData_next = s_axi_wdata;
         wStrb_next = s_axi_wstrb;
      end
      if (doWrite)
      begin
         awHeld_next = 1'b0;
         wHeld_next = 1'b0;
         bValid_next = 1'b1;
         case (awAddr_reg)
            ADDR_MODE, ADDR_CLK, ADDR_CTRL, ADDR_CNT0, ADDR_CNT1:
               okAddr = 1'b1;
            default: okAddr = 1'b0;
         endcase
         bResp_next = okAddr ? RESP_OKAY : RESP_SLVERR;
      end
      if (bValid_reg && s_axi_bready)
         bValid_next = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         rValid_next = 1'b1;
         rResp_next = RESP_OKAY;
         rData_next = 32'h0000_0000;
         case (s_axi_araddr)
            ADDR_MODE: rData_next[7:0] = mode_reg;
            ADDR_CLK: rData_next[7:0] = clk_reg & CLK_IMPL_MASK;
            ADDR_CTRL:
            begin
               rData_next[CTRL_RUN0_BIT] = run0_reg;
               rData_next[CTRL_RUN1_BIT] = run1_reg;
               rData_next[CTRL_OVF0_BIT] = ovf0_reg;
               rData_next[CTRL_OVF1_BIT] = ovf1_reg;
            end
            ADDR_CNT0: rData_next[15:0] = {th0_reg, tl0_reg};
            ADDR_CNT1: rData_next[15:0] = {th1_reg, tl1_reg};
            default: rResp_next = RESP_SLVERR;
         endcase
      end
      else if (rValid_reg && s_axi_rready)
         rValid_next = 1'b0;
   end
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         awAddr_reg <= 8'h00;
         wData_reg <= 32'h0000_0000;
         wStrb_reg <= 4'h0;
         bValid_reg <= 1'b0;
         bResp_reg <= RESP_OKAY;
         rValid_reg <= 1'b0;
         rResp_reg <= RESP_OKAY;
         rData_reg <= 32'h0000_0000;
      end
      else
      begin
         awHeld_reg <= awHeld_next;
         wHeld_reg <= wHeld_next;
         awAddr_reg <= awAddr_next;
         wData_reg <= wData_next;
         wStrb_reg <= wStrb_next;
         bValid_reg <= bValid_next;
         bResp_reg <= bResp_next;
         rValid_reg <= rValid_next;
         rResp_reg <= rResp_next;
         rData_reg <= rData_next;
      end
   end
   // configuration, counting and flags
   always_comb
   begin
      cfg0 = timer_cfg_t'(mode_reg[MODE_T0_LSB +: 4]);
      cfg1 = timer_cfg_t'(mode_reg[MODE_T1_LSB +: 4]);
      split = (cfg0.mode == MODE_SPLIT);
      en0 = run0_reg && (!cfg0.gate || firstExtInterruptInputN);
      if (split)
         en1 = (cfg1.mode != MODE_SPLIT);
      else
         en1 = run1_reg && (!cfg1.gate || secondExtInterruptInputN)
            && (cfg1.mode != MODE_SPLIT);
      hiEn = split && run1_reg;
      hiTick = clk_reg[CLK_T0SEL_BIT] || preTick;
      st0 = step(cfg0.mode, th0_reg, tl0_reg);
      st1 = step(cfg1.mode, th1_reg, tl1_reg);
      wrCnt0 = doWrite && (awAddr_reg == ADDR_CNT0);
      wrCnt1 = doWrite && (awAddr_reg == ADDR_CNT1);
      mode_next = mode_reg;
      clk_next = clk_reg;
      run0_next = run0_reg;
      run1_next = run1_reg;
      tl0_next = tl0_reg;
      th0_next = th0_reg;
      tl1_next = tl1_reg;
      th1_next = th1_reg;
      set0 = 1'b0;
      set1 = 1'b0;
      if (tick0 && en0)
      begin
         tl0_next = st0[7:0];
         if (!split)
            th0_next = st0[15:8];
         set0 = st0[16];
      end
      if (hiEn && hiTick)
      begin
         th0_next = th0_reg + 8'h01;
         set1 = (th0_reg == 8'hFF);
      end
      if (tick1 && en1)
      begin
         {th1_next, tl1_next} = st1[15:0];
         if (!split)
            set1 = st1[16];
      end
      ovf0_next = ovf0_reg;
      ovf1_next = ovf1_reg;
      if (doWrite && wStrb_reg[0])
      begin
         case (awAddr_reg)
            ADDR_MODE: mode_next = wData_reg[7:0];
            ADDR_CLK: clk_next = wData_reg[7:0] & CLK_IMPL_MASK;
            ADDR_CTRL:
            begin
               run0_next = wData_reg[CTRL_RUN0_BIT];
               run1_next = wData_reg[CTRL_RUN1_BIT];
               if (wData_reg[CTRL_OVF0_BIT])
                  ovf0_next = 1'b0;
               if (wData_reg[CTRL_OVF1_BIT])
                  ovf1_next = 1'b0;
            end
            default: ;
         endcase
      end
      // software load wins over a count step
      if (wrCnt0 && wStrb_reg[0])
         tl0_next = wData_reg[7:0];
      if (wrCnt0 && wStrb_reg[1])
         th0_next = wData_reg[15:8];
      if (wrCnt1 && wStrb_reg[0])
         tl1_next = wData_reg[7:0];
      if (wrCnt1 && wStrb_reg[1])
         th1_next = wData_reg[15:8];
      // hardware set wins over software clear
      ovf0_next = ovf0_next | set0;
      ovf1_next = ovf1_next | set1;
   end
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         mode_reg <= MODE_RESET;
         clk_reg <= CLK_RESET;
         run0_reg <= 1'b0;
         run1_reg <= 1'b0;
         ovf0_reg <= 1'b0;
         ovf1_reg <= 1'b0;
         tl0_reg <= CNT_RESET;
         th0_reg <= CNT_RESET;
         tl1_reg <= CNT_RESET;
         th1_reg <= CNT_RESET;
      end
      else
      begin
         mode_reg <= mode_next;
         clk_reg <= clk_next;
         run0_reg <= run0_next;
         run1_reg <= run1_next;
         ovf0_reg <= ovf0_next;
         ovf1_reg <= ovf1_next;
         tl0_reg <= tl0_next;
         th0_reg <= th0_next;
         tl1_reg <= tl1_next;
         th1_reg <= th1_next;
      end
   end
   a_clk_top_zero: assert property (@(posedge mclk) disable iff (!rstn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_CLK)
      |=> (s_axi_rvalid && s_axi_rdata[7:5] == 3'h0))
      else $error("clock register top bits not zero");
   a_gate_blocks: assert property (@(posedge mclk) disable iff (!rstn)
      (!en0 && !wrCnt0 && !split) |=> (tl0_reg == $past(tl0_reg)))
      else $error("timer 0 counted while disabled");
   a_reload_value: assert property (@(posedge mclk) disable iff (!rstn)
      (cfg0.mode == MODE_RELOAD8 && tick0 && en0 && tl0_reg == 8'hFF
      && !wrCnt0) |=> (tl0_reg == $past(th0_reg) && ovf0_reg))
      else $error("auto-reload did not reload");
   a_split_flag: assert property (@(posedge mclk) disable iff (!rstn)
      (hiEn && hiTick && th0_reg == 8'hFF) |=> ovf1_reg)
      else $error("split upper byte overflow not flagged");
   a_write_answer: assert property (@(posedge mclk) disable iff (!rstn)
      (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
      |=> ##1 s_axi_bvalid)
      else $error("write response late");
endmodule

// ===== rtl/tmr_pkg.sv
package tmr_pkg;
   // bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // register byte addresses
   localparam logic [7:0] ADDR_MODE = 8'h00;
   localparam logic [7:0] ADDR_CLK = 8'h04;
   localparam logic [7:0] ADDR_CTRL = 8'h08;
   localparam logic [7:0] ADDR_CNT0 = 8'h0C;
   localparam logic [7:0] ADDR_CNT1 = 8'h10;
   // reset values
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] CLK_RESET = 8'h00;
   localparam logic [7:0] CNT_RESET = 8'h00;
   // field positions
   localparam int MODE_T0_LSB = 0;
   localparam int MODE_T1_LSB = 4;
   localparam int CLK_SCA_LSB = 0;
   localparam int CLK_T0SEL_BIT = 3;
   localparam int CLK_T1SEL_BIT = 4;
   localparam logic [7:0] CLK_IMPL_MASK = 8'h1B;
   localparam int CTRL_RUN0_BIT = 0;
   localparam int CTRL_RUN1_BIT = 1;
   localparam int CTRL_OVF0_BIT = 4;
   localparam int CTRL_OVF1_BIT = 5;
   // prescaler divisors
   localparam int DIV_A = 12;
   localparam int DIV_B = 4;
   localparam int DIV_C = 48;
   localparam int DIV_EXT = 8;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_RELOAD8,
      MODE_SPLIT} tmode_t;
   typedef enum logic [1:0] {PRE_DIV12, PRE_DIV4, PRE_DIV48,
      PRE_EXT8} presc_t;
   // one nibble of the mode register
   typedef struct packed {
      logic gate;
      logic counterSel;
      tmode_t mode;
   } timer_cfg_t;
endpackage

// ===== rtl/tmr_prescaler.sv
`timescale 1ns/100ps
module tmr_prescaler
   import tmr_pkg::*;
(
   input wire logic mclk, // system clock
   input wire logic rstn, // async reset, low
   input wire tmr_pkg::presc_t sel, // prescale select
   input wire logic extClk, // external clock, sync to mclk
   output logic tick // one-cycle prescaled pulse
);
   logic [5:0] cnt_reg, cnt_next;
   logic extPrev_reg, extPrev_next;
   logic [5:0] limit;
   logic step;

   // divider count and limit per select
   always_comb
   begin
      extPrev_next = extClk;
      step = 1'b1;
      case (sel)
         PRE_DIV12: limit = 6'(DIV_A - 1);
         PRE_DIV4: limit = 6'(DIV_B - 1);
         PRE_DIV48: limit = 6'(DIV_C - 1);
         PRE_EXT8:
         begin
            limit = 6'(DIV_EXT - 1);
            step = extClk & ~extPrev_reg;
         end
         default: limit = 6'(DIV_A - 1);
      endcase
      tick = step && (cnt_reg >= limit);
      cnt_next = cnt_reg;
      if (step)
         cnt_next = (cnt_reg >= limit) ? 6'h00 : cnt_reg + 6'h01;
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_reg <= 6'h00;
         extPrev_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         extPrev_reg <= extPrev_next;
      end
   end

   a_div4_period: assert property (@(posedge mclk) disable iff (!rstn)
      (tick && sel == PRE_DIV4) ##1 (sel == PRE_DIV4 && !tick)[*3]
      |=> tick)
      else $error("divide-by-4 tick period wrong");
endmodule

// ===== rtl/tmr_count_source.sv
`timescale 1ns/100ps
module tmr_count_source
(
   input wire logic mclk, // system clock
   input wire logic rstn, // async reset, low
   input wire logic clkSel, // 1 system clock, 0 prescaled
   input wire logic counterSel, // 1 count pin edges
   input wire logic extAllowed, // pin may clock the timer
   input wire logic prescaleTick, // shared prescaled pulse
   input wire logic countPin, // external count input
   output logic tick // one-cycle count strobe
);
   logic pinPrev_reg, pinPrev_next;
   logic fall;

   // falling-edge detect and source choice
   always_comb
   begin
      pinPrev_next = countPin;
      fall = pinPrev_reg & ~countPin;
      if (counterSel && extAllowed)
         tick = fall;
      else if (clkSel)
         tick = 1'b1;
      else
         tick = prescaleTick;
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         pinPrev_reg <= 1'b1;
      else
         pinPrev_reg <= pinPrev_next;
   end

   a_pin_edge_only: assert property (@(posedge mclk) disable iff (!rstn)
      (counterSel && extAllowed) |-> (tick == ($past(countPin) && !countPin)))
      else $error("counter tick not tied to pin fall");
   a_sel_ignored: assert property (@(posedge mclk) disable iff (!rstn)
      (counterSel && extAllowed && clkSel && countPin) |-> !tick)
      else $error("clock select leaked into counter mode");
   a_timer_source: assert property (@(posedge mclk) disable iff (!rstn)
      !counterSel |-> (tick == (clkSel || prescaleTick)))
      else $error("timer source select wrong");
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import tmr_pkg::*;
   typedef struct packed {
      logic [31:0] exp;
      logic [31:0] mask;
      logic [1:0] resp;
   } rexp_t;
   logic mclk, rstn, extClk, pin0, pin1, intN0, intN1, ovf0, ovf1;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp;
   logic awRS, wRS, arRS, bVS, rVS;
   logic [1:0] bRS, rRS;
   logic f0S, f1S;
   logic [31:0] rDS, x, y, rnd;
   int miscompares, checkCount, cyc, arCyc, i;
   rexp_t rq[$];
   rexp_t re;
   logic [1:0] wq[$];
   logic [1:0] we;

   legacy_timer_mode_clock_select uut (.mclk(mclk), .rstn(rstn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .firstTimerCountPin(pin0), .secondTimerCountPin(pin1),
      .firstExtInterruptInputN(intN0), .secondExtInterruptInputN(intN1),
      .extClk(extClk), .firstTimerOverflowFlag(ovf0),
      .secondTimerOverflowFlag(ovf1));

   // clock
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // cycle count and free-running external clock
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      extClk <= ~extClk;
   end

   // outputs sampled mid-cycle, settled for the next edge
   always @(negedge mclk)
   begin
      awRS <= awready;
      wRS <= wready;
      arRS <= arready;
      bVS <= bvalid;
      bRS <= bresp;
      rVS <= rvalid;
      rRS <= rresp;
      rDS <= rdata;
      f0S <= ovf0;
      f1S <= ovf1;
   end

   task automatic check(input logic [31:0] seen, exp, input string nm);
      checkCount++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic finishTest;
      $display("compares %0d mismatches %0d", checkCount, miscompares);
      if (miscompares == 0 && checkCount > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // response monitor: oldest note against each answer
   always @(posedge mclk)
   begin
      if (bready && bVS)
      begin
         we = wq.pop_front();
         check({30'h0, bRS}, {30'h0, we}, "bresp");
      end
      if (rready && rVS)
      begin
         re = rq.pop_front();
         check({30'h0, rRS}, {30'h0, re.resp}, "rresp");
         check(rDS & re.mask, re.exp & re.mask, "rdata");
      end
   end

   task automatic axWrite(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
      int n;
      wq.push_back(er);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 200; n++)
      begin
         @(posedge mclk);
         if (awvalid && awRS)
            awvalid <= 1'b0;
         if (wvalid && wRS)
            wvalid <= 1'b0;
         if (bVS)
         begin
            bready <= 1'b0;
            break;
         end
      end
      if (n == 200)
      begin
         miscompares++;
         finishTest;
      end
      // one idle edge so the next call never re-drives bready at once
      @(posedge mclk);
   endtask

   task automatic axRead(input logic [7:0] a, input logic [31:0] e, m,
      input logic [1:0] er, output logic [31:0] d);
      int n;
      rq.push_back('{e, m, er});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 200; n++)
      begin
         @(posedge mclk);
         if (arvalid && arRS)
         begin
            arvalid <= 1'b0;
            arCyc = cyc;
         end
         if (rVS)
         begin
            d = rDS;
            rready <= 1'b0;
            break;
         end
      end
      if (n == 200)
      begin
         miscompares++;
         finishTest;
      end
      // one idle edge so the next call never re-drives rready at once
      @(posedge mclk);
   endtask

   // counting rate over a window: dv 0 none, 1 every cycle, else per dv
   task automatic rate(input logic [7:0] a, input int dv);
      logic [31:0] p, q;
      int c0, d, e;
      axRead(a, 32'h0, 32'h0, RESP_OKAY, p);
      c0 = arCyc;
      repeat (480) @(posedge mclk);
      axRead(a, 32'h0, 32'h0, RESP_OKAY, q);
      d = int'(q[15:0] - p[15:0]);
      e = (dv == 0) ? 0 : (arCyc - c0) / dv;
      check({31'h0, d == e || (dv > 1 && d == e + 1)}, 32'h1,
         "count rate");
   endtask

   // n falling edges on a count pin, then the count must grow by n
   task automatic pulses(input logic [7:0] a, input int n);
      logic [31:0] p, q;
      axRead(a, 32'h0, 32'h0, RESP_OKAY, p);
      repeat (n)
      begin
         @(posedge mclk);
         if (a == ADDR_CNT0) pin0 <= 1'b0; else pin1 <= 1'b0;
         repeat (3) @(posedge mclk);
         if (a == ADDR_CNT0) pin0 <= 1'b1; else pin1 <= 1'b1;
         repeat (3) @(posedge mclk);
      end
      repeat (4) @(posedge mclk);
      axRead(a, 32'h0, 32'h0, RESP_OKAY, q);
      check({16'h0, q[15:0] - p[15:0]}, n, "pin edges");
   endtask

   // watchdog
   initial
   begin
      repeat (50000) @(posedge mclk);
      miscompares++;
      finishTest;
   end

   initial
   begin
      {awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready} = '0;
      {arvalid, rready, cyc, extClk, miscompares, checkCount} = '0;
      {pin0, pin1, intN0, intN1} = 4'hF;
      rstn = 1'b0;
      rnd = $urandom(32'h3fa38e23);
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      // reset values and register access
      axRead(ADDR_MODE, MODE_RESET, 32'hFFFFFFFF, RESP_OKAY, x);
      axRead(ADDR_CLK, CLK_RESET, 32'hFFFFFFFF, RESP_OKAY, x);
      for (i = 0; i < 6; i++)
      begin
         rnd = $urandom();
         axWrite(ADDR_MODE, rnd, RESP_OKAY);
         axRead(ADDR_MODE, {24'h0, rnd[7:0]}, 32'hFFFFFFFF, RESP_OKAY,
            x);
         axWrite(ADDR_CLK, rnd | 32'hE0, RESP_OKAY);
         axRead(ADDR_CLK, rnd & CLK_IMPL_MASK, 32'hFFFFFFFF, RESP_OKAY,
            x);
      end
      axWrite(8'h20, 32'hFF, RESP_SLVERR);
      axRead(8'h20, 32'h0, 32'hFFFFFFFF, RESP_SLVERR, x);
      // timer 0 timer function, system clock then each prescale
      axWrite(ADDR_MODE, 32'h01, RESP_OKAY);
      axWrite(ADDR_CLK, 32'h08, RESP_OKAY);
      axWrite(ADDR_CTRL, 32'h01, RESP_OKAY);
      rate(ADDR_CNT0, 1);
      axWrite(ADDR_CLK, 32'h00, RESP_OKAY);
      rate(ADDR_CNT0, DIV_A);
      axWrite(ADDR_CLK, 32'h01, RESP_OKAY);
      rate(ADDR_CNT0, DIV_B);
      axWrite(ADDR_CLK, 32'h02, RESP_OKAY);
      rate(ADDR_CNT0, DIV_C);
      axWrite(ADDR_CLK, 32'h03, RESP_OKAY);
      rate(ADDR_CNT0, 2 * DIV_EXT);
      // timer 0 counter function ignores its clock select
      axWrite(ADDR_MODE, 32'h05, RESP_OKAY);
      axWrite(ADDR_CLK, 32'h08, RESP_OKAY);
      rate(ADDR_CNT0, 0);
      pulses(ADDR_CNT0, 5);
      // gate: counts only while the interrupt input is high
      axWrite(ADDR_MODE, 32'h09, RESP_OKAY);
      intN0 <= 1'b0;
      rate(ADDR_CNT0, 0);
      intN0 <= 1'b1;
      rate(ADDR_CNT0, 1);
      // timer 1
      axWrite(ADDR_MODE, 32'h10, RESP_OKAY);
      axWrite(ADDR_CLK, 32'h10, RESP_OKAY);
      axWrite(ADDR_CTRL, 32'h02, RESP_OKAY);
      rate(ADDR_CNT1, 1);
      axWrite(ADDR_CLK, 32'h00, RESP_OKAY);
      rate(ADDR_CNT1, DIV_A);
      axWrite(ADDR_MODE, 32'h50, RESP_OKAY);
      axWrite(ADDR_CLK, 32'h10, RESP_OKAY);
      rate(ADDR_CNT1, 0);
      pulses(ADDR_CNT1, 3);
      axWrite(ADDR_MODE, 32'h30, RESP_OKAY);
      rate(ADDR_CNT1, 0);
      // split mode: upper byte on timer 1 run, timer 1 flag
      axWrite(ADDR_CTRL, 32'h30, RESP_OKAY);
      axWrite(ADDR_MODE, 32'h03, RESP_OKAY);
      axWrite(ADDR_CLK, 32'h08, RESP_OKAY);
      axWrite(ADDR_CNT0, 32'hF000, RESP_OKAY);
      axWrite(ADDR_CTRL, 32'h02, RESP_OKAY);
      repeat (100) @(posedge mclk);
      axRead(ADDR_CNT0, 32'h0, 32'hFF, RESP_OKAY, x);
      axRead(ADDR_CTRL, 32'h20, 32'h30, RESP_OKAY, x);
      check({30'h0, f1S, f0S}, 32'h2, "split flags");
      axWrite(ADDR_CTRL, 32'h00, RESP_OKAY);
      axWrite(ADDR_CTRL, 32'h20, RESP_OKAY);
      check({31'h0, f1S}, 32'h0, "flag clear");
      // auto-reload: high byte kept, flag set
      axWrite(ADDR_MODE, 32'h02, RESP_OKAY);
      axWrite(ADDR_CNT0, 32'hA5FE, RESP_OKAY);
      axWrite(ADDR_CTRL, 32'h11, RESP_OKAY);
      repeat (100) @(posedge mclk);
      axRead(ADDR_CNT0, 32'hA500, 32'hFF00, RESP_OKAY, y);
      check({31'h0, f0S}, 32'h1, "reload flag");
      check({31'h0, y[7:0] >= 8'hA5}, 32'h1, "reload low");
      repeat (4) @(posedge mclk);
      finishTest;
   end
endmodule
